//--- pkg/isr_regs.vh
`ifndef ISR_REGS_VH
`define ISR_REGS_VH

// instance numbers
`define ISR_INST_QUES       16'h000b
`define ISR_INST_OPER       16'h000d
`define ISR_INST_OUT_SET    16'h000f
`define ISR_INST_OUT_GET    16'h0010
`define ISR_INST_CURR       16'h0101
`define ISR_INST_VOLT       16'h0102
`define ISR_INST_PWR        16'h0103

// services
`define ISR_SVC_GET         1'b0
`define ISR_SVC_SET         1'b1

// answer status codes
`define ISR_ST_OK           2'h0
`define ISR_ST_REJECT       2'h1
`define ISR_ST_UNKNOWN      2'h2

// answer word counts
`define ISR_CNT_NONE        2'h0
`define ISR_CNT_ONE         2'h1
`define ISR_CNT_TWO         2'h2

// questionable word fields
`define ISR_Q_OVP           0
`define ISR_Q_OCT           1
`define ISR_Q_OVT           2
`define ISR_Q_OPT           3
`define ISR_Q_OCP           4
`define ISR_Q_OTP           5
`define ISR_Q_RSL           6
`define ISR_Q_CC            7
`define ISR_Q_CV            8
`define ISR_Q_CR            9
`define ISR_Q_CP            10
`define ISR_Q_SOFT          11
`define ISR_Q_HARD          12
`define ISR_Q_ILOCK         13
`define ISR_Q_INPWR         14
`define ISR_Q_IOFLT         15

// operation word 0 fields
`define ISR_W0_STANDBY      0
`define ISR_W0_LIVE         1
`define ISR_W0_OCT          4
`define ISR_W0_OVT          5
`define ISR_W0_OPT          6
`define ISR_W0_SENSE        7
`define ISR_W0_UVT          8
`define ISR_W0_CUR_RATE     16
`define ISR_W0_VOLT_RATE    17
`define ISR_W0_ILOCK        20

// operation word 1 fields
`define ISR_W1_PHASE        0
`define ISR_W1_RATING       16
`define ISR_W1_FIRMWARE     17

// reset values
`define ISR_RST_OUT_EN      1'b0
`define ISR_RST_WORD        32'h0000_0000

`endif

//--- src/isr_status_regs.v
// Operation
// - questionable word live, get instance 11
// - reads never clear any status bit
// - hard faults at bits 0,4,5,6
// - soft trips at bits 1,2,3
// - regulation state on bits 7 to 10
// - bit 11 ors all soft faults
// - bit 12 ors all hard faults
// - bits 13-15 interlock, input power, io fault
// - two operation words live, instance 13
// - word0 bit0 standby, bit1 active
// - word0 trips 4-6, sense 7, undervoltage 8
// - word0 bits 16,17 ratings, 20 interlock
// - word1 bits 0, 16, 17 flags
// - questionable trips and interlock are fixed operation subset
// - output enable set 15, get 16
// - instance 257 returns averaged current
// - 258 returns voltage, sense when engaged
// - instance 259 returns averaged power
`timescale 1ns/1ps
`include "isr_regs.vh"

module isr_status_regs
(
    input  wire        CLK_I,
    input  wire        RESET_N_I,
    input  wire        REQ_VALID_I,
    input  wire        REQ_SERVICE_I,
    input  wire [15:0] REQ_INSTANCE_I,
    input  wire [31:0] REQ_DATA_I,
    output reg         RSP_VALID_O,
    output reg  [1:0]  RSP_STATUS_O,
    output reg  [1:0]  RSP_COUNT_O,
    output reg  [31:0] RSP_DATA0_O,
    output reg  [31:0] RSP_DATA1_O,
    output reg         OUTPUT_ENABLE_O,
    input  wire        OVERVOLTAGE_HARD_FAULT_I,
    input  wire        OVERCURRENT_HARD_FAULT_I,
    input  wire        OVER_TEMPERATURE_I,
    input  wire        SENSE_LEAD_LOSS_I,
    input  wire        OVERCURRENT_TRIP_FLAG_I,
    input  wire        OVERVOLTAGE_TRIP_FLAG_I,
    input  wire        OVERPOWER_TRIP_FLAG_I,
    input  wire        LOW_VOLTAGE_TRIP_I,
    input  wire        SENSE_OUT_OF_BOUNDS_I,
    input  wire        CONST_CURRENT_REG_I,
    input  wire        CONST_VOLTAGE_REG_I,
    input  wire        CONST_RESISTANCE_REG_I,
    input  wire        CONST_POWER_REG_I,
    input  wire        INTERLOCK_OPEN_I,
    input  wire        INPUT_POWER_LOST_I,
    input  wire        IO_SIGNAL_FAULT_I,
    input  wire        TERMINAL_CURRENT_OVER_RATING_I,
    input  wire        TERMINAL_VOLTAGE_OVER_RATING_I,
    input  wire        MISSING_PHASE_I,
    input  wire        BAD_SYSTEM_RATING_I,
    input  wire        FIRMWARE_MISMATCH_I,
    input  wire        POWER_ACTIVE_I,
    input  wire        SENSE_ENGAGED_I,
    input  wire [31:0] AVG_CURRENT_I,
    input  wire [31:0] AVG_TERMINAL_VOLTAGE_I,
    input  wire [31:0] AVG_SENSE_VOLTAGE_I,
    input  wire [31:0] AVG_POWER_I
);

    // ----------------------------------------------------------------
    // live status words
    // ----------------------------------------------------------------
    wire        soft_fault_any;
    wire        hard_fault_any;
    reg  [31:0] ques_word;
    reg  [31:0] oper_word0;
    reg  [31:0] oper_word1;

    assign soft_fault_any = OVERCURRENT_TRIP_FLAG_I | OVERVOLTAGE_TRIP_FLAG_I
                          | OVERPOWER_TRIP_FLAG_I;
    assign hard_fault_any = OVERVOLTAGE_HARD_FAULT_I | OVERCURRENT_HARD_FAULT_I
                          | OVER_TEMPERATURE_I | SENSE_LEAD_LOSS_I;

    always @*
    begin
        ques_word = `ISR_RST_WORD;
        ques_word[`ISR_Q_OVP]   = OVERVOLTAGE_HARD_FAULT_I;
        ques_word[`ISR_Q_OCP]   = OVERCURRENT_HARD_FAULT_I;
        ques_word[`ISR_Q_OTP]   = OVER_TEMPERATURE_I;
        ques_word[`ISR_Q_RSL]   = SENSE_LEAD_LOSS_I;
        ques_word[`ISR_Q_OCT]   = OVERCURRENT_TRIP_FLAG_I;
        ques_word[`ISR_Q_OVT]   = OVERVOLTAGE_TRIP_FLAG_I;
        ques_word[`ISR_Q_OPT]   = OVERPOWER_TRIP_FLAG_I;
        ques_word[`ISR_Q_CC]    = CONST_CURRENT_REG_I;
        ques_word[`ISR_Q_CV]    = CONST_VOLTAGE_REG_I;
        ques_word[`ISR_Q_CR]    = CONST_RESISTANCE_REG_I;
        ques_word[`ISR_Q_CP]    = CONST_POWER_REG_I;
        ques_word[`ISR_Q_SOFT]  = soft_fault_any;
        ques_word[`ISR_Q_HARD]  = hard_fault_any;
        ques_word[`ISR_Q_ILOCK] = INTERLOCK_OPEN_I;
        ques_word[`ISR_Q_INPWR] = INPUT_POWER_LOST_I;
        ques_word[`ISR_Q_IOFLT] = IO_SIGNAL_FAULT_I;
    end

    // same source signals feed both views, so the subset stays fixed
    always @*
    begin
        oper_word0 = `ISR_RST_WORD;
        oper_word0[`ISR_W0_STANDBY]   = ~POWER_ACTIVE_I;
        oper_word0[`ISR_W0_LIVE]      = POWER_ACTIVE_I;
        oper_word0[`ISR_W0_OCT]       = OVERCURRENT_TRIP_FLAG_I;
        oper_word0[`ISR_W0_OVT]       = OVERVOLTAGE_TRIP_FLAG_I;
        oper_word0[`ISR_W0_OPT]       = OVERPOWER_TRIP_FLAG_I;
        oper_word0[`ISR_W0_SENSE]     = SENSE_OUT_OF_BOUNDS_I;
        oper_word0[`ISR_W0_UVT]       = LOW_VOLTAGE_TRIP_I;
        oper_word0[`ISR_W0_CUR_RATE]  = TERMINAL_CURRENT_OVER_RATING_I;
        oper_word0[`ISR_W0_VOLT_RATE] = TERMINAL_VOLTAGE_OVER_RATING_I;
        oper_word0[`ISR_W0_ILOCK]     = INTERLOCK_OPEN_I;
        oper_word1 = `ISR_RST_WORD;
        oper_word1[`ISR_W1_PHASE]     = MISSING_PHASE_I;
        oper_word1[`ISR_W1_RATING]    = BAD_SYSTEM_RATING_I;
        oper_word1[`ISR_W1_FIRMWARE]  = FIRMWARE_MISMATCH_I;
    end

    // ----------------------------------------------------------------
    // instance decode
    // ----------------------------------------------------------------
    // instances this bank answers at all
    function known_inst;
        input [15:0] inst;
        begin
            case (inst)
                `ISR_INST_QUES,
                `ISR_INST_OPER,
                `ISR_INST_OUT_SET,
                `ISR_INST_OUT_GET,
                `ISR_INST_CURR,
                `ISR_INST_VOLT,
                `ISR_INST_PWR:
                begin
                    known_inst = 1'b1;
                end
                default:
                begin
                    known_inst = 1'b0;
                end
            endcase
        end
    endfunction

    // only the output enable instance takes a set
    function set_inst;
        input [15:0] inst;
        begin
            set_inst = (inst == `ISR_INST_OUT_SET);
        end
    endfunction

    // data words carried by an accepted get
    function [1:0] get_words;
        input [15:0] inst;
        begin
            case (inst)
                `ISR_INST_OPER:
                begin
                    get_words = `ISR_CNT_TWO;
                end
                `ISR_INST_QUES,
                `ISR_INST_OUT_GET,
                `ISR_INST_CURR,
                `ISR_INST_VOLT,
                `ISR_INST_PWR:
                begin
                    get_words = `ISR_CNT_ONE;
                end
                default:
                begin
                    get_words = `ISR_CNT_NONE;
                end
            endcase
        end
    endfunction

    wire        req_known;
    wire        req_set;
    wire        req_accept;
    wire        req_get_ok;

    assign req_known  = known_inst(REQ_INSTANCE_I);
    assign req_set    = set_inst(REQ_INSTANCE_I);
    // a set only on the enable instance, a get on every other one
    assign req_accept = req_known & ((REQ_SERVICE_I == `ISR_SVC_SET) == req_set);
    assign req_get_ok = REQ_VALID_I & req_accept & ~req_set;

    // ----------------------------------------------------------------
    // answer status
    // ----------------------------------------------------------------
    reg         next_valid;
    reg  [1:0]  next_status;
    reg  [1:0]  next_count;
    reg         next_out_en;

    always @*
    begin
        next_valid  = REQ_VALID_I;
        next_status = `ISR_ST_OK;
        next_count  = `ISR_CNT_NONE;
        next_out_en = OUTPUT_ENABLE_O;
        if (REQ_VALID_I && !req_known)
        begin
            next_status = `ISR_ST_UNKNOWN;
        end
        else if (REQ_VALID_I && !req_accept)
        begin
            // wrong service for the instance: nothing changes
            next_status = `ISR_ST_REJECT;
        end
        else if (REQ_VALID_I && req_set)
        begin
            next_out_en = REQ_DATA_I[0];
        end
        else if (REQ_VALID_I)
        begin
            next_count = get_words(REQ_INSTANCE_I);
        end
    end

    // ----------------------------------------------------------------
    // answer data select
    // ----------------------------------------------------------------
    reg  [31:0] next_data0;
    reg  [31:0] next_data1;

    // refused and set answers carry zero words
    always @*
    begin
        next_data0 = `ISR_RST_WORD;
        next_data1 = `ISR_RST_WORD;
        if (req_get_ok)
        begin
            case (REQ_INSTANCE_I)
                `ISR_INST_QUES:
                begin
                    next_data0 = ques_word;
                end
                `ISR_INST_OPER:
                begin
                    next_data0 = oper_word0;
                    next_data1 = oper_word1;
                end
                `ISR_INST_OUT_GET:
                begin
                    next_data0 = {31'h0, OUTPUT_ENABLE_O};
                end
                `ISR_INST_CURR:
                begin
                    next_data0 = AVG_CURRENT_I;
                end
                `ISR_INST_VOLT:
                begin
                    next_data0 = SENSE_ENGAGED_I ? AVG_SENSE_VOLTAGE_I
                                                 : AVG_TERMINAL_VOLTAGE_I;
                end
                `ISR_INST_PWR:
                begin
                    next_data0 = AVG_POWER_I;
                end
                default:
                begin
                    next_data0 = `ISR_RST_WORD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // answer registers
    // ----------------------------------------------------------------
    always @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            RSP_VALID_O  <= 1'b0;
            RSP_STATUS_O <= `ISR_ST_OK;
            RSP_COUNT_O  <= `ISR_CNT_NONE;
            RSP_DATA0_O  <= `ISR_RST_WORD;
            RSP_DATA1_O  <= `ISR_RST_WORD;
        end
        else
        begin
            RSP_VALID_O  <= next_valid;
            RSP_STATUS_O <= next_status;
            RSP_COUNT_O  <= next_count;
            RSP_DATA0_O  <= next_data0;
            RSP_DATA1_O  <= next_data1;
        end
    end

    // ----------------------------------------------------------------
    // output enable state
    // ----------------------------------------------------------------
    // held across gets; only an accepted set or reset moves it
    always @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            OUTPUT_ENABLE_O <= `ISR_RST_OUT_EN;
        end
        else
        begin
            OUTPUT_ENABLE_O <= next_out_en;
        end
    end

endmodule

//--- dv/isr_status_regs_chk.sv
`timescale 1ns/1ps
module isr_chk
(
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        REQ_VALID_I,
    input wire logic        REQ_SERVICE_I,
    input wire logic [15:0] REQ_INSTANCE_I,
    input wire logic [31:0] REQ_DATA_I,
    input wire logic        RSP_VALID_O,
    input wire logic [1:0]  RSP_STATUS_O,
    input wire logic [1:0]  RSP_COUNT_O,
    input wire logic [31:0] RSP_DATA0_O,
    input wire logic        OUTPUT_ENABLE_O
);
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    wire logic get_q = REQ_VALID_I && !REQ_SERVICE_I;
    wire logic set_q = REQ_VALID_I && REQ_SERVICE_I;
    wire logic en_q  = REQ_INSTANCE_I == 16'h000f;
    wire logic known = REQ_INSTANCE_I inside {16'h000b, 16'h000d, 16'h000f, 16'h0010,
                                              16'h0101, 16'h0102, 16'h0103};
    rsp_next_a: assert property (
        REQ_VALID_I |=> RSP_VALID_O) else $error("answer missing");
    rsp_cause_a: assert property (
        RSP_VALID_O |-> $past(REQ_VALID_I)) else $error("answer without request");
    get_unknown_a: assert property (
        get_q && !known |=> RSP_STATUS_O == 2'h2 && RSP_COUNT_O == 2'h0)
        else $error("unknown instance not flagged");
    set_reject_a: assert property (
        set_q && known && !en_q |=> RSP_STATUS_O == 2'h1 && RSP_DATA0_O == 32'h0)
        else $error("set to read-only not refused");
    oper_pair_a: assert property (
        get_q && REQ_INSTANCE_I == 16'h000d |=> RSP_COUNT_O == 2'h2 && RSP_STATUS_O == 2'h0)
        else $error("operation words not paired");
    enable_set_a: assert property (
        set_q && en_q |=> OUTPUT_ENABLE_O == $past(REQ_DATA_I[0])) else $error("enable not set");
    enable_hold_a: assert property (
        !(set_q && en_q) |=> $stable(OUTPUT_ENABLE_O)) else $error("enable changed");
    enable_read_a: assert property (
        get_q && REQ_INSTANCE_I == 16'h0010 |=> RSP_DATA0_O == {31'h0, OUTPUT_ENABLE_O})
        else $error("enable readback wrong");
endmodule

//--- dv/isr_ctrl_model.sv
`timescale 1ns/1ps
module isr_ctrl_model
(
    input  wire logic        clk_i,
    output logic             req_valid_o,
    output logic             req_service_o,
    output logic [15:0]      req_instance_o,
    output logic [31:0]      req_data_o,
    input  wire logic        rsp_valid_i,
    input  wire logic [1:0]  rsp_status_i,
    input  wire logic [1:0]  rsp_count_i,
    input  wire logic [31:0] rsp_data0_i,
    input  wire logic [31:0] rsp_data1_i
);
    logic        got_v;
    logic [1:0]  got_s;
    logic [1:0]  got_c;
    logic [31:0] got0;
    logic [31:0] got1;
    initial {req_valid_o, req_service_o, req_instance_o, req_data_o} = '0;
    // one request, answer taken in the cycle after the taking edge
    task automatic xfer(input logic s, input logic [15:0] n, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b1;
        req_service_o = s;
        req_instance_o = n;
        req_data_o = d;
        @(posedge clk_i);
        #1;
        {got_v, got_s, got_c, got0, got1} = {rsp_valid_i, rsp_status_i, rsp_count_i,
                                             rsp_data0_i, rsp_data1_i};
        req_valid_o = 1'b0;
        req_service_o = ~s;
        req_instance_o = ~n;
        req_data_o = ~d;
    endtask
endmodule

//--- dv/tb_instrument_status_and_measure_regs.sv
`timescale 1ns/1ps
module tb_instrument_status_and_measure_regs;
    logic        clk;
    logic        reset_n;
    logic        en;
    logic [31:0] st;
    logic [31:0] d;
    logic [31:0] seed = 32'h0001_1d31;
    logic [31:0] fl [4];
    logic [15:0] ins [7] = '{16'h000b, 16'h000d, 16'h000f, 16'h0010, 16'h0101, 16'h0102, 16'h0103};
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    wire         v, s, rv, oe;
    wire  [15:0] n;
    wire  [31:0] rd, r0, r1;
    wire  [1:0]  rs, rc;
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    isr_ctrl_model u_ctl (.clk_i(clk), .req_valid_o(v), .req_service_o(s), .req_instance_o(n),
        .req_data_o(rd), .rsp_valid_i(rv), .rsp_status_i(rs), .rsp_count_i(rc),
        .rsp_data0_i(r0), .rsp_data1_i(r1));
    isr_status_regs u_dut (.CLK_I(clk), .RESET_N_I(reset_n), .REQ_VALID_I(v), .REQ_SERVICE_I(s),
        .REQ_INSTANCE_I(n), .REQ_DATA_I(rd), .RSP_VALID_O(rv), .RSP_STATUS_O(rs),
        .RSP_COUNT_O(rc), .RSP_DATA0_O(r0), .RSP_DATA1_O(r1), .OUTPUT_ENABLE_O(oe),
        .OVERVOLTAGE_HARD_FAULT_I(st[0]), .OVERCURRENT_HARD_FAULT_I(st[1]),
        .OVER_TEMPERATURE_I(st[2]), .SENSE_LEAD_LOSS_I(st[3]), .OVERCURRENT_TRIP_FLAG_I(st[4]),
        .OVERVOLTAGE_TRIP_FLAG_I(st[5]), .OVERPOWER_TRIP_FLAG_I(st[6]), .LOW_VOLTAGE_TRIP_I(st[7]),
        .SENSE_OUT_OF_BOUNDS_I(st[8]), .CONST_CURRENT_REG_I(st[9]), .CONST_VOLTAGE_REG_I(st[10]),
        .CONST_RESISTANCE_REG_I(st[11]), .CONST_POWER_REG_I(st[12]), .INTERLOCK_OPEN_I(st[13]),
        .INPUT_POWER_LOST_I(st[14]), .IO_SIGNAL_FAULT_I(st[15]),
        .TERMINAL_CURRENT_OVER_RATING_I(st[16]), .TERMINAL_VOLTAGE_OVER_RATING_I(st[17]),
        .MISSING_PHASE_I(st[18]), .BAD_SYSTEM_RATING_I(st[19]), .FIRMWARE_MISMATCH_I(st[20]),
        .POWER_ACTIVE_I(st[21]), .SENSE_ENGAGED_I(st[22]), .AVG_CURRENT_I(fl[0]),
        .AVG_TERMINAL_VOLTAGE_I(fl[1]), .AVG_SENSE_VOLTAGE_I(fl[2]), .AVG_POWER_I(fl[3]));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected first word per instance index, index 7 is operation word 1
    function automatic logic [31:0] e0(input int k);
        case (k)
            0: return {16'h0, st[15:13], |st[3:0], |st[6:4], st[12:9], st[3:1], st[6:4], st[0]};
            1: return {11'h0, st[13], 2'h0, st[17:16], 7'h0, st[7], st[8], st[6:4], 2'h0,
                       st[21], !st[21]};
            3: return {31'h0, en};
            4: return fl[0];
            5: return st[22] ? fl[2] : fl[1];
            6: return fl[3];
            7: return {14'h0, st[20:19], 15'h0, st[18]};
            default: return 32'h0;
        endcase
    endfunction
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            $display("[FAIL] %0t %s", $time, m);
            n_errors++;
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            $display("[FAIL] %0t timeout", $time);
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        st = 32'h0;
        en = 1'b0;
        d = 32'h0;
        foreach (fl[k]) fl[k] = 32'h0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        for (int i = 0; i < 30; i++)
        begin
            st = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : rnd();
            foreach (fl[k]) fl[k] = rnd();
            foreach (ins[k])
            begin
                d = rnd();
                u_ctl.xfer(1'b1, ins[k], d);
                if (k == 2) en = d[0];
                chk(u_ctl.got_s === (k == 2 ? 2'h0 : 2'h1) && u_ctl.got0 === 32'h0 && oe === en,
                    "set service");
            end
            repeat (2) foreach (ins[k])
            begin
                u_ctl.xfer(1'b0, ins[k], rnd());
                chk(u_ctl.got_v === 1'b1 && u_ctl.got_s === (k == 2 ? 2'h1 : 2'h0)
                    && u_ctl.got0 === e0(k) && u_ctl.got1 === (k == 1 ? e0(7) : 32'h0)
                    && u_ctl.got_c === (k == 1 ? 2'h2 : k == 2 ? 2'h0 : 2'h1),
                    "get service");
            end
            u_ctl.xfer(1'b0, {4'h8, d[11:0]}, d);
            chk(u_ctl.got_s === 2'h2 && u_ctl.got_c === 2'h0, "unknown instance");
        end
        u_ctl.xfer(1'b1, 16'h000f, 32'h1);
        reset_n = 1'b0;
        #1;
        chk(oe === 1'b0 && rv === 1'b0, "outputs during reset");
        @(posedge clk);
        #1 reset_n = 1'b1;
        u_ctl.xfer(1'b0, 16'h0010, 32'h0);
        chk(u_ctl.got0 === 32'h0, "enable after reset");
        summarize();
    end
endmodule
bind isr_status_regs isr_chk u_chk (.CLK_I, .RESET_N_I, .REQ_VALID_I, .REQ_SERVICE_I,
    .REQ_INSTANCE_I, .REQ_DATA_I, .RSP_VALID_O, .RSP_STATUS_O, .RSP_COUNT_O, .RSP_DATA0_O,
    .OUTPUT_ENABLE_O);
